// [design/bfc_core.sv]
// bus fault classifier, frame builder and unstack/rerun sequencer
// assumes bus controller and core signals are on sys_clk, registers on plain port
// Notes on behaviour
// (RQ1) function code stacked low, reloaded on rerun
// (RQ2) unused status bits stacked zero, ignored
// (RQ3) four fault categories
// (RQ4) released write taken at next boundary
// (RQ5) operand access while pending aborts instruction
// (RQ6) released write status pattern with rerun set
// (RQ7) released frame holds pc, sr, address, data
// (RQ8) reads, prefetches, locked cycles are restartable
// (RQ9) restartable fault aborts and restores address regs
// (RQ10) restartable clears trace/move/rerun, keeps breakpoints
// (RQ11) block-move transfers own category, fetches restartable
// (RQ12) block-move fault aborts without register restore
// (RQ13) block-move sets move bit, rerun on writes
// (RQ14) block-move frame: next address, 16 minus tries
// (RQ15) fault during fault processing halts
// (RQ16) exception-processing fault stacks faulted frame contents
// (RQ17) second half of long sets long flag
// (RQ18) return restores state, requeues pending traps
// (RQ19) only rerun bit tested; reload fields, rerun
// (RQ20) handler adjusts address and size for long
// (RQ21) handler clears rerun after software completion
// (RQ22) restartable fault refetches aborted instruction
// (RQ23) size code: long 00, byte 01, word 10
// (RQ24) direction set for reads, clear for writes
// (RQ25) status word field layout
`timescale 1ns/1ps
module bfc_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [bfc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fault_valid,
  input wire bfc_pkg::bfc_cyc_t fault_cyc,
  input wire bfc_pkg::bfc_ctx_t core_ctx,
  input wire logic insn_boundary,
  input wire logic operand_access,
  input wire logic exception_return_op,
  input wire logic rerun_done,
  output logic exc_take,
  output logic abort_insn,
  output logic restore_ea_regs,
  output logic halt_double,
  output logic rerun_req,
  output bfc_pkg::bfc_rerun_t rerun_cyc,
  output logic rerun_discard,
  output logic requeue_trace,
  output logic [1:0] requeue_bp,
  output logic refetch_insn,
  output logic move_continue,
  output logic frame_rebuild
);
  import bfc_pkg::*;

  bfc_state_t state_r;
  logic [15:0] ssw_r;
  logic [31:0] faddr_r;
  logic [31:0] dbuf_r;
  logic [31:0] pc_r;
  logic [15:0] sr_r;
  logic [15:0] fv_r;
  logic [31:0] xpc_r;
  logic [7:0] xcnt_r;
  logic in_fault_exc_r;

  function automatic logic [15:0] build_ssw(input logic tp, input logic mv, input logic tr,
      input logic b1, input logic b0, input logic rr, input logic rm, input logic inb,
      input logic rw, input logic lg, input logic [1:0] sz, input logic [2:0] fc);
    logic [15:0] w;
    w = 16'h0000;
    w[SSW_TP] = tp;
    w[SSW_MV] = mv;
    w[SSW_TR] = tr;
    w[SSW_B1] = b1;
    w[SSW_B0] = b0;
    w[SSW_RR] = rr;
    w[SSW_RM] = rm;
    w[SSW_IN] = inb;
    w[SSW_RW] = rw;
    w[SSW_LG] = lg;
    w[SSW_SZ_LO +: 2] = sz;
    w[SSW_FC_LO +: 3] = fc;
    return w & SSW_USED_MASK; // RQ2 RQ25
  endfunction : build_ssw

  // classification of a fault seen in the idle state
  logic f_idle;
  logic f_double;
  logic f_exc;
  logic f_move;
  logic f_rel;
  logic f_rst;
  assign f_idle = fault_valid && (state_r == ST_IDLE);
  assign f_double = f_idle && fault_cyc.exc && core_ctx.exc_fault; // RQ15
  assign f_exc = f_idle && fault_cyc.exc && !core_ctx.exc_fault; // RQ3 RQ16
  assign f_move = f_idle && !fault_cyc.exc && fault_cyc.mvx && !fault_cyc.pref; // RQ11
  assign f_rel = f_idle && !fault_cyc.exc && !f_move && fault_cyc.released && !fault_cyc.rd;
  assign f_rst = f_idle && !fault_cyc.exc && !f_move && !f_rel; // RQ8

  logic pend_take;
  logic pend_abort;
  logic rte_go;
  assign pend_take = (state_r == ST_PEND) && (insn_boundary || operand_access); // RQ4
  assign pend_abort = (state_r == ST_PEND) && operand_access; // RQ5
  assign rte_go = exception_return_op && (state_r == ST_IDLE) && in_fault_exc_r;

  logic sw_wr_ssw;
  assign sw_wr_ssw = reg_wr && (reg_addr == REG_SSW);

  // sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (f_double) begin
            state_r <= ST_HALT; // RQ15
          end else if (f_rel) begin
            state_r <= ST_PEND;
          end else if (rte_go && ssw_r[SSW_RR]) begin
            state_r <= ST_RERUN; // RQ19
          end
        end
        ST_PEND: begin
          if (pend_take) begin
            state_r <= ST_IDLE;
          end
        end
        ST_RERUN: begin
          if (rerun_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_HALT: begin
          state_r <= ST_HALT;
        end
      endcase
    end
  end

  // fault status word: hardware capture wins over a same-cycle software write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ssw_r <= SSW_RST;
    end else if (f_exc) begin
      ssw_r <= build_ssw(1'b1, 1'b0, core_ctx.trace, core_ctx.bp1, core_ctx.bp0, 1'b0,
        1'b0, 1'b0, fault_cyc.rd, fault_cyc.long_hi, fault_cyc.size, fault_cyc.fc); // RQ16
    end else if (f_move) begin
      ssw_r <= build_ssw(1'b0, 1'b1, core_ctx.trace, core_ctx.bp1, core_ctx.bp0,
        !fault_cyc.rd, 1'b0, fault_cyc.pref, fault_cyc.rd, fault_cyc.long_hi,
        fault_cyc.size, fault_cyc.fc); // RQ13 RQ24
    end else if (f_rel) begin
      ssw_r <= build_ssw(1'b0, 1'b0, core_ctx.trace, core_ctx.bp1, core_ctx.bp0, 1'b1,
        1'b0, 1'b0, 1'b0, fault_cyc.long_hi, fault_cyc.size, fault_cyc.fc); // RQ6 RQ17
    end else if (f_rst) begin
      ssw_r <= build_ssw(1'b0, 1'b0, 1'b0, core_ctx.bp1, core_ctx.bp0, 1'b0,
        fault_cyc.rmw, fault_cyc.pref, fault_cyc.rd, fault_cyc.long_hi,
        fault_cyc.size, fault_cyc.fc); // RQ10 RQ1
    end else if (pend_take) begin
      // pending traps refreshed when the released write is finally taken
      ssw_r[SSW_TR] <= core_ctx.trace; // RQ6
      ssw_r[SSW_B1] <= core_ctx.bp1;
      ssw_r[SSW_B0] <= core_ctx.bp0;
    end else if (sw_wr_ssw) begin
      ssw_r <= reg_wdata[15:0] & SSW_USED_MASK; // RQ2 RQ21
    end
  end

  // fault address, output buffer, transfer count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      faddr_r <= 32'h0000_0000;
      dbuf_r <= 32'h0000_0000;
      xcnt_r <= 8'h00;
    end else if (f_move) begin
      faddr_r <= core_ctx.mv_addr; // RQ14
      dbuf_r <= fault_cyc.data;
      xcnt_r <= XFER_BASE - {3'h0, core_ctx.mv_tries}; // RQ14
    end else if (f_idle && !f_double) begin
      faddr_r <= fault_cyc.addr; // RQ7
      dbuf_r <= fault_cyc.data;
      xcnt_r <= 8'h00;
    end else if (reg_wr && reg_addr == REG_FADDR) begin
      faddr_r <= reg_wdata; // RQ20
    end else if (reg_wr && reg_addr == REG_DBUF) begin
      dbuf_r <= reg_wdata;
    end
  end

  // program counter, status register, faulted exception frame contents
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= 32'h0000_0000;
      sr_r <= 16'h0000;
      fv_r <= 16'h0000;
      xpc_r <= 32'h0000_0000;
    end else if (f_exc) begin
      pc_r <= core_ctx.next_pc; // RQ16
      sr_r <= core_ctx.sr;
      fv_r <= core_ctx.fv;
      xpc_r <= core_ctx.six_word ? core_ctx.insn_pc : 32'h0000_0000;
    end else if (f_move || f_rst) begin
      pc_r <= core_ctx.insn_pc; // RQ22
      sr_r <= core_ctx.sr;
    end else if (pend_take) begin
      pc_r <= core_ctx.next_pc; // RQ4 RQ7
      sr_r <= core_ctx.sr;
    end else if (reg_wr && reg_addr == REG_PC) begin
      pc_r <= reg_wdata;
    end else if (reg_wr && reg_addr == REG_SRFV) begin
      sr_r <= reg_wdata[15:0];
      fv_r <= reg_wdata[31:16];
    end else if (reg_wr && reg_addr == REG_XPC) begin
      xpc_r <= reg_wdata;
    end
  end

  // a fault exception is being handled until its return
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_fault_exc_r <= 1'b0;
    end else if (f_exc || f_move || f_rst || pend_take) begin
      in_fault_exc_r <= 1'b1;
    end else if (rte_go) begin
      in_fault_exc_r <= 1'b0;
    end
  end

  // exception entry strobes and the sticky double-fault halt flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      exc_take <= 1'b0;
      abort_insn <= 1'b0;
      restore_ea_regs <= 1'b0;
      halt_double <= 1'b0;
    end else begin
      exc_take <= f_exc || f_move || f_rst || pend_take; // RQ3
      abort_insn <= f_move || f_rst || pend_abort; // RQ5 RQ9 RQ12
      restore_ea_regs <= f_rst; // RQ9 RQ12
      halt_double <= halt_double || f_double; // RQ15
    end
  end

  // unstack strobes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      requeue_trace <= 1'b0;
      requeue_bp <= 2'b00;
      refetch_insn <= 1'b0;
      move_continue <= 1'b0;
      frame_rebuild <= 1'b0;
    end else begin
      requeue_trace <= rte_go && ssw_r[SSW_TR]; // RQ18
      requeue_bp <= rte_go ? {ssw_r[SSW_B1], ssw_r[SSW_B0]} : 2'b00; // RQ18
      refetch_insn <= rte_go && !ssw_r[SSW_TP] && !ssw_r[SSW_MV] && !ssw_r[SSW_RR]; // RQ22
      move_continue <= rte_go && ssw_r[SSW_MV]; // RQ13
      frame_rebuild <= rte_go && ssw_r[SSW_TP] && !ssw_r[SSW_RR];
    end
  end

  // rerun request: fields reloaded from the stacked status word, fault address and data buffer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rerun_req <= 1'b0;
      rerun_cyc <= '0;
      rerun_discard <= 1'b0;
    end else if (rte_go && ssw_r[SSW_RR]) begin
      rerun_req <= 1'b1; // RQ19
      rerun_cyc.fc <= ssw_r[SSW_FC_LO +: 3]; // RQ1
      rerun_cyc.size <= ssw_r[SSW_SZ_LO +: 2]; // RQ23
      rerun_cyc.rd <= ssw_r[SSW_RW];
      rerun_cyc.addr <= faddr_r; // RQ18
      rerun_cyc.data <= dbuf_r;
      rerun_discard <= ssw_r[SSW_RW]; // RQ19
    end else if (state_r == ST_RERUN && rerun_done) begin
      rerun_req <= 1'b0;
      rerun_discard <= 1'b0;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_SSW: reg_rdata <= {16'h0000, ssw_r};
        REG_FADDR: reg_rdata <= faddr_r;
        REG_DBUF: reg_rdata <= dbuf_r;
        REG_PC: reg_rdata <= pc_r;
        REG_SRFV: reg_rdata <= {fv_r, sr_r};
        REG_XPC: reg_rdata <= xpc_r;
        REG_XCNT: reg_rdata <= {24'h000000, xcnt_r};
        REG_STAT: reg_rdata <= {28'h0000000, in_fault_exc_r, halt_double, state_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_double_halt: assert property (f_double |=> halt_double [*3]) // RQ15
    else $error("double fault did not halt");
  a_restart_frame: assert property (f_rst |=> abort_insn && restore_ea_regs
      && !ssw_r[SSW_TR] && !ssw_r[SSW_RR] && !ssw_r[SSW_MV]) // RQ10
    else $error("restartable fault frame wrong");
  a_move_count: assert property (f_move |=> ssw_r[SSW_MV] && !restore_ea_regs
      && !ssw_r[SSW_RM] && xcnt_r == XFER_BASE - {3'h0, $past(core_ctx.mv_tries)}) // RQ14
    else $error("block move frame wrong");
  a_release_pend: assert property (f_rel |=> state_r == ST_PEND && ssw_r[SSW_RR]
      && !exc_take && ssw_r[15:13] == 3'h0 && ssw_r[8:6] == 3'h0) // RQ6
    else $error("released write not held pending");
  a_pend_abort: assert property (pend_abort |=> abort_insn && exc_take
      && pc_r == $past(core_ctx.next_pc)) // RQ5
    else $error("operand access did not abort");
  a_rerun_fields: assert property (rte_go && ssw_r[SSW_RR] |=> rerun_req
      && rerun_cyc.fc == $past(ssw_r[2:0]) && rerun_cyc.size == $past(ssw_r[4:3])) // RQ19
    else $error("rerun fields not reloaded");
  a_unused_zero: assert property (reg_rd && reg_addr == REG_SSW |=> reg_rdata[13] == 1'b0
      && reg_rdata[31:16] == 16'h0000) // RQ2
    else $error("unused status bit set");
  a_refetch: assert property (rte_go && ssw_r[15:14] == 2'b00 && !ssw_r[SSW_RR]
      |=> refetch_insn ##1 !refetch_insn) // RQ22
    else $error("restart did not refetch");
  a_rerun_hold: assert property (rerun_req && !rerun_done |=> rerun_req) // RQ19
    else $error("rerun request dropped");

endmodule : bfc_core

// [design/bfc_pkg.sv]
// bus fault classify/stack package: frame layout, register map, carriers
// assumes one core clock domain shared by the bus controller and the block
package bfc_pkg;

  // fault status word bit positions
  localparam int unsigned SSW_TP = 15;
  localparam int unsigned SSW_MV = 14;
  localparam int unsigned SSW_TR = 12;
  localparam int unsigned SSW_B1 = 11;
  localparam int unsigned SSW_B0 = 10;
  localparam int unsigned SSW_RR = 9;
  localparam int unsigned SSW_RM = 8;
  localparam int unsigned SSW_IN = 7;
  localparam int unsigned SSW_RW = 6;
  localparam int unsigned SSW_LG = 5;
  localparam int unsigned SSW_SZ_LO = 3;
  localparam int unsigned SSW_FC_LO = 0;
  // bits that carry state; all others stack as zero and are ignored
  localparam logic [15:0] SSW_USED_MASK = 16'hdfff;
  localparam logic [15:0] SSW_RST = 16'h0000;

  // remaining size codes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // block-move transfer count base
  localparam logic [7:0] XFER_BASE = 8'h10;

  // register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_SSW = 8'h00;
  localparam logic [7:0] REG_FADDR = 8'h04;
  localparam logic [7:0] REG_DBUF = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0c;
  localparam logic [7:0] REG_SRFV = 8'h10;
  localparam logic [7:0] REG_XPC = 8'h14;
  localparam logic [7:0] REG_XCNT = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;

  // faulted bus cycle as reported by the bus controller
  typedef struct packed {
    logic [2:0] fc;
    logic [1:0] size;
    logic rd;
    logic long_hi;
    logic rmw;
    logic pref;
    logic mvx;
    logic released;
    logic exc;
    logic [31:0] addr;
    logic [31:0] data;
  } bfc_cyc_t;

  // core context sampled with a fault or a boundary
  typedef struct packed {
    logic [31:0] next_pc;
    logic [31:0] insn_pc;
    logic [15:0] sr;
    logic trace;
    logic bp1;
    logic bp0;
    logic exc_fault;
    logic [31:0] mv_addr;
    logic [4:0] mv_tries;
    logic [15:0] fv;
    logic six_word;
  } bfc_ctx_t;

  // rerun request towards the bus controller
  typedef struct packed {
    logic [2:0] fc;
    logic [1:0] size;
    logic rd;
    logic [31:0] addr;
    logic [31:0] data;
  } bfc_rerun_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PEND = 2'b01,
    ST_RERUN = 2'b11,
    ST_HALT = 2'b10
  } bfc_state_t;

endpackage : bfc_pkg

// [tb/bfc_busctl_model.sv]
// bus controller model: completes rerun cycles after a set latency
// assumes rerun_req is held until the cycle after rerun_done, one core clock
`timescale 1ns/1ps
module bfc_busctl_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rerun_req,
  input wire logic [3:0] lat,
  output logic rerun_done,
  output logic [7:0] reruns
);
  logic [3:0] wait_r;
  // one done pulse per request, after lat idle cycles
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 4'h0;
      rerun_done <= 1'b0;
      reruns <= 8'h00;
    end else if (rerun_req && !rerun_done && wait_r == lat) begin
      rerun_done <= 1'b1;
      reruns <= reruns + 8'h01;
      wait_r <= 4'h0;
    end else begin
      rerun_done <= 1'b0;
      wait_r <= (rerun_req && !rerun_done) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : bfc_busctl_model

// [tb/tb_top.sv]
// self-checking bench for the bus fault classifier
// assumes 20 MHz sys_clk, active-low async reset, bus controller model beside it
`timescale 1ns/1ps
module tb_top;
  import bfc_pkg::*;
`define CHK(nm, e, g) chk(nm, 72'(e), 72'(g))
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic fault_valid = 1'b0, insn_boundary = 1'b0, operand_access = 1'b0, ret = 1'b0;
  bfc_cyc_t cyc = '0, cv = '0;
  bfc_ctx_t ctx = '0, xv = '0;
  logic exc_take, abort_insn, restore_ea_regs, halt_double, rerun_req, rerun_discard;
  logic requeue_trace, refetch_insn, move_continue, frame_rebuild, rerun_done;
  logic [1:0] requeue_bp;
  bfc_rerun_t rerun_cyc;
  logic [3:0] lat = 4'h1;
  logic [7:0] reruns;
  int error_cnt = 0, checked = 0, cycles = 0;
  integer seed = 32'hf02c6156;

  bfc_core u_bfc_core (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault_valid(fault_valid), .fault_cyc(cyc), .core_ctx(ctx),
    .insn_boundary(insn_boundary), .operand_access(operand_access),
    .exception_return_op(ret), .rerun_done(rerun_done), .exc_take(exc_take),
    .abort_insn(abort_insn), .restore_ea_regs(restore_ea_regs),
    .halt_double(halt_double), .rerun_req(rerun_req), .rerun_cyc(rerun_cyc),
    .rerun_discard(rerun_discard), .requeue_trace(requeue_trace),
    .requeue_bp(requeue_bp), .refetch_insn(refetch_insn),
    .move_continue(move_continue), .frame_rebuild(frame_rebuild));
  bfc_busctl_model u_bfc_busctl_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .rerun_req(rerun_req), .lat(lat), .rerun_done(rerun_done), .reruns(reruns));

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [15:0] fault_status_word(logic tp, mv, tr, b1, b0, rr, rm, in_, rw, lg,
      logic [1:0] sz, logic [2:0] fc);
    return {tp, mv, 1'b0, tr, b1, b0, rr, rm, in_, rw, lg, sz, fc};
  endfunction : fault_status_word

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(nm, e, reg_rdata & m);
  endtask : rd

  // k = {fault, return, operand access, boundary}
  task automatic kick(logic [3:0] k);
    @(posedge sys_clk);
    cyc <= cv;
    ctx <= xv;
    {fault_valid, ret, operand_access, insn_boundary} <= k;
    @(posedge sys_clk);
    {fault_valid, ret, operand_access, insn_boundary} <= 4'h0;
    #1;
  endtask : kick

  task automatic drain();
    for (int n = 0; n < 20 && rerun_req === 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK("rerun end", 0, rerun_req);
  endtask : drain

  task automatic summarize();
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 9; a++) rd("rst", 8'(a * 4), 0);
    // restartable faults, random cycle kinds
    for (int i = 0; i < 8; i++) begin
      cv = '0;
      {cv.fc, cv.size, cv.rmw, cv.pref, cv.long_hi} = 8'($random(seed));
      if (cv.size == 2'h3) cv.size = SIZE_BYTE;
      cv.rd = cv.pref | 1'($random(seed));
      cv.addr = $random(seed);
      xv = '0;
      {xv.trace, xv.bp1, xv.bp0} = 3'($random(seed));
      kick(4'h8);
      `CHK("rs take", 3'h7, {exc_take, abort_insn, restore_ea_regs});
      rd("rs ssw", REG_SSW, fault_status_word(0, 0, 0, xv.bp1, xv.bp0, 0, cv.rmw, cv.pref, cv.rd,
        cv.long_hi, cv.size, cv.fc));
      rd("rs addr", REG_FADDR, cv.addr);
      kick(4'h4);
      `CHK("rs ret", {4'h8, xv.bp1, xv.bp0, 2'h0},
        {refetch_insn, rerun_req, move_continue, requeue_trace, requeue_bp, 2'h0});
    end
    // released write, second half of a long word
    cv = '0;
    cv.fc = 3'h5;
    cv.size = SIZE_WORD;
    cv.long_hi = 1'b1;
    cv.released = 1'b1;
    cv.addr = 32'h1000_0002;
    cv.data = $random(seed);
    xv = '0;
    xv.trace = 1'b1;
    xv.bp0 = 1'b1;
    xv.next_pc = $random(seed);
    xv.sr = 16'h2704;
    kick(4'h8);
    `CHK("rw early", 0, exc_take);
    kick(4'h1);
    `CHK("rw bound", 2'h2, {exc_take, abort_insn});
    rd("rw ssw", REG_SSW, fault_status_word(0, 0, 1, 0, 1, 1, 0, 0, 0, 1, SIZE_WORD, 3'h5));
    rd("rw pc", REG_PC, xv.next_pc);
    rd("rw sr", REG_SRFV, {16'h0, xv.sr});
    rd("rw addr", REG_FADDR, cv.addr);
    rd("rw data", REG_DBUF, cv.data);
    // handler widens the rerun to the whole long word
    wr(REG_FADDR, cv.addr - 32'h2);
    wr(REG_SSW, fault_status_word(0, 0, 1, 0, 1, 1, 0, 0, 0, 1, SIZE_LONG, 3'h5) | 16'h2000);
    rd("rw wr", REG_SSW, fault_status_word(0, 0, 1, 0, 1, 1, 0, 0, 0, 1, SIZE_LONG, 3'h5));
    kick(4'h4);
    `CHK("rw ret", 4'hd, {rerun_req, requeue_trace, requeue_bp});
    `CHK("rw cyc", {3'h5, SIZE_LONG, 1'b0, cv.addr - 32'h2, cv.data}, rerun_cyc);
    drain();
    // operand access while pending, rerun turned into a read
    lat = 4'h6;
    kick(4'h8);
    kick(4'h2);
    `CHK("rw opnd", 2'h3, {exc_take, abort_insn});
    wr(REG_SSW, fault_status_word(0, 0, 0, 0, 0, 1, 0, 0, 1, 1, SIZE_WORD, 3'h5));
    kick(4'h4);
    `CHK("rw rd", 3'h7, {rerun_req, rerun_discard, rerun_cyc.rd});
    drain();
    // write finished by software, rerun flag cleared
    kick(4'h8);
    kick(4'h1);
    wr(REG_SSW, fault_status_word(0, 0, 1, 0, 0, 0, 0, 0, 0, 1, SIZE_WORD, 3'h5));
    kick(4'h4);
    `CHK("rw sw", 2'h1, {rerun_req, requeue_trace});
    // block move: write then read fault, count 13 then 0
    for (int r = 0; r < 2; r++) begin
      cv = '0;
      cv.mvx = 1'b1;
      cv.rd = r[0];
      cv.fc = 3'h1;
      cv.size = SIZE_WORD;
      xv.mv_addr = $random(seed);
      xv.mv_tries = 5'(3 + r * 13);
      kick(4'h8);
      `CHK("mv take", 3'h6, {exc_take, abort_insn, restore_ea_regs});
      rd("mv ssw", REG_SSW, fault_status_word(0, 1, 1, 0, 1, !r[0], 0, 0, r[0], 0, SIZE_WORD, 3'h1));
      rd("mv addr", REG_FADDR, xv.mv_addr);
      rd("mv cnt", REG_XCNT, XFER_BASE - 8'(xv.mv_tries));
      kick(4'h4);
      `CHK("mv ret", r ? 2'h1 : 2'h3, {rerun_req, move_continue});
      drain();
    end
    `CHK("reruns", 3, reruns);
    // fault while stacking a six-word frame
    cv = '0;
    cv.exc = 1'b1;
    cv.rd = 1'b1;
    xv.six_word = 1'b1;
    xv.insn_pc = $random(seed);
    xv.fv = 16'h2018;
    kick(4'h8);
    `CHK("ex take", 1, exc_take);
    rd("ex ssw", REG_SSW, 32'h9400, 32'hdc00);
    rd("ex srfv", REG_SRFV, {xv.fv, xv.sr});
    rd("ex xpc", REG_XPC, xv.insn_pc);
    kick(4'h4);
    `CHK("ex ret", 1, frame_rebuild);
    // second fault inside fault processing
    xv.exc_fault = 1'b1;
    kick(4'h8);
    `CHK("halt", 1, halt_double);
    kick(4'h1);
    rd("halt st", REG_STAT, 32'h4, 32'h4);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 `CHK("halt rst", 0, halt_double);
    summarize();
  end
endmodule : tb_top
